//--- design/ebcs_top.sv
// External expansion bus strobe, bank chip selects and bus sequencing.
`default_nettype none
module ebcs_top
  import ebcs_pkg::*;
#(
  parameter int STROBE_CYCLES = STROBE_CYCLES_DEF
)
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Access request from the core
  input wire logic REQ_VALID,
  input wire logic [15:0] REQ_ADDR,
  input wire logic REQ_WRITE,
  input wire logic REQ_FETCH,
  input wire logic [7:0] REQ_WDATA,
  input wire logic [4:0] BANK_PARK_HIGH,
  output logic REQ_READY,
  output logic REQ_ACK,
  output logic [7:0] RD_DATA,
  // Expansion bus pins
  output logic [7:0] ADDRESS_LOW_BYTE_PORT,
  output logic [7:0] ADDRESS_HIGH_BYTE_PORT,
  output logic READ_WRITE,
  output logic OPCODE_FETCH_INDICATOR_N,
  output logic EXTERNAL_DATA_STROBE_N,
  output logic EIGHTH_BANK_SELECT_FIRST_N,
  output logic EIGHTH_BANK_SELECT_SECOND_N,
  output logic HALF_BANK_SELECT_FIRST_N,
  output logic HALF_BANK_SELECT_SECOND_N,
  output logic HALF_BANK_SELECT_THIRD_N,
  output logic PERIPHERAL_FRAME_SELECT_N,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE
);
  // ****************************************************************
  // Checks and declarations
  // ****************************************************************
  // The synchroniser delays read data by two cycles, so a shorter strobe
  // would capture data from before the strobe fell.
  // The strobe counter is eight bits wide, so longer strobes cannot be timed.
  if ((STROBE_CYCLES < SYNC_STAGES + 1) || (STROBE_CYCLES > 256))
  begin : g_bad_strobe
    $error("STROBE_CYCLES must lie between three and 256");
  end

  localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYCLES - 1);

  ebcs_state_t state;
  ebcs_state_t next_state;
  logic [7:0] cnt;
  logic [7:0] data_sync;
  logic [15:0] acc_addr;
  logic acc_write;
  logic acc_fetch;
  logic [5:0] acc_sel;
  logic acc_ext;
  logic [15:0] next_addr;
  logic [7:0] next_cnt;
  logic [6:0] next_pins;
  logic take;
  logic dec_pf;
  logic dec_e1;
  logic dec_e2;
  logic dec_h1;
  logic dec_h2;
  logic dec_h3;
  logic next_strobe_low;
  logic next_oe;
  logic strobe_end;

  ebcs_sync #(.WIDTH(8)) u_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .din(DATA_IN),
    .dout(data_sync)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic in_frame(input logic [15:0] a);
    in_frame = (a >= PF_FRAME_LO) && (a <= PF_FRAME_HI);
  endfunction

  assign take = REQ_VALID && REQ_READY;
  assign dec_pf = in_frame(REQ_ADDR); // R7
  // Eighth banks win over the half bank that overlaps them.
  assign dec_e1 = REQ_ADDR[15:13] == EIGHTH_FIRST_BLK; // R8
  assign dec_e2 = REQ_ADDR[15:13] == EIGHTH_SECOND_BLK; // R8
  assign dec_h1 = (REQ_ADDR[15:14] == HALF_FIRST_BLK) && !dec_e1 && !dec_e2; // R8
  assign dec_h2 = (REQ_ADDR[15:14] == HALF_SECOND_BLK) && !dec_e1 && !dec_e2; // R8
  assign dec_h3 = (REQ_ADDR[15:14] == HALF_THIRD_BLK) && !dec_e1 && !dec_e2; // R8

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  assign strobe_end = (state == S_STROBE) && (cnt == STROBE_LAST);

  always_comb
  begin
    next_state = state;
    unique case (state)
      S_IDLE:
        if (take)
          next_state = S_SETUP;
      S_SETUP:
        next_state = acc_ext ? S_STROBE : S_HOLD;
      S_STROBE:
        if (strobe_end)
          next_state = S_HOLD;
      S_HOLD:
        next_state = S_IDLE;
    endcase
  end

  assign next_cnt = (state == S_STROBE) ? cnt + 8'h01 : 8'h00;
  assign next_addr = take ? REQ_ADDR : acc_addr;
  assign next_strobe_low = (next_state == S_STROBE) && acc_ext; // R1
  // Write data rides from the falling strobe edge to one cycle past its rise.
  assign next_oe = acc_write && acc_ext &&
                   ((next_state == S_STROBE) || (next_state == S_HOLD)); // R3
  // A parked pin is a general-purpose output held high: never selects.
  assign next_pins = next_strobe_low ?
                     ~({1'b1, acc_sel} & {1'b1, ~BANK_PARK_HIGH, 1'b1}) :
                     7'h7F; // R4 R5 R6 R12

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      state <= S_IDLE;
      cnt <= 8'h00;
      acc_addr <= ADDR_RST;
      acc_write <= 1'b0;
      acc_fetch <= 1'b0;
      acc_sel <= 6'h00;
      acc_ext <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      acc_addr <= next_addr;
      if (take)
      begin
        acc_write <= REQ_WRITE;
        acc_fetch <= REQ_FETCH && !REQ_WRITE;
        acc_sel <= {dec_e1, dec_e2, dec_h1, dec_h2, dec_h3, dec_pf};
        acc_ext <= dec_pf || (REQ_ADDR >= EXT_BASE);
      end
    end
  end

  // ****************************************************************
  // Registered pins and answers
  // ****************************************************************
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      REQ_READY <= 1'b1;
      REQ_ACK <= 1'b0;
      RD_DATA <= BYTE_RST;
      ADDRESS_LOW_BYTE_PORT <= ADDR_RST[7:0];
      ADDRESS_HIGH_BYTE_PORT <= ADDR_RST[15:8];
      READ_WRITE <= 1'b1;
      OPCODE_FETCH_INDICATOR_N <= 1'b1;
      {EXTERNAL_DATA_STROBE_N, EIGHTH_BANK_SELECT_FIRST_N, EIGHTH_BANK_SELECT_SECOND_N,
       HALF_BANK_SELECT_FIRST_N, HALF_BANK_SELECT_SECOND_N, HALF_BANK_SELECT_THIRD_N,
       PERIPHERAL_FRAME_SELECT_N} <= {1'b1, SEL_IDLE, 1'b1};
      DATA_OUT <= BYTE_RST;
      DATA_OE <= 1'b0;
    end
    else
    begin
      REQ_READY <= next_state == S_IDLE;
      REQ_ACK <= next_state == S_HOLD;
      if (strobe_end && !acc_write)
        RD_DATA <= data_sync; // R2
      ADDRESS_LOW_BYTE_PORT <= next_addr[7:0]; // R11
      ADDRESS_HIGH_BYTE_PORT <= next_addr[15:8]; // R11
      READ_WRITE <= take ? !REQ_WRITE : ((next_state == S_IDLE) || !acc_write); // R9
      OPCODE_FETCH_INDICATOR_N <= take ? !(REQ_FETCH && !REQ_WRITE) :
                                  !(acc_fetch && (next_state != S_IDLE)); // R10
      {EXTERNAL_DATA_STROBE_N, EIGHTH_BANK_SELECT_FIRST_N, EIGHTH_BANK_SELECT_SECOND_N,
       HALF_BANK_SELECT_FIRST_N, HALF_BANK_SELECT_SECOND_N, HALF_BANK_SELECT_THIRD_N,
       PERIPHERAL_FRAME_SELECT_N} <= next_pins; // R1 R4 R5 R7
      if (take)
        DATA_OUT <= REQ_WDATA;
      DATA_OE <= next_oe; // R3
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  AST_STROBE_IDLE_HIGH: assert property ((state == S_IDLE) |-> EXTERNAL_DATA_STROBE_N) // R1
    else $error("Strobe low with no access in progress.");
  AST_STROBE_WIDTH: assert property ($fell(EXTERNAL_DATA_STROBE_N) |->
      !EXTERNAL_DATA_STROBE_N [*3] ##0 (cnt == 8'h02)) // R1
    else $error("Strobe low period shorter than expected.");
  AST_READ_CAPTURE: assert property ((strobe_end && !acc_write) |=> (RD_DATA == $past(data_sync))) // R2
    else $error("Read data not taken at strobe rise.");
  AST_WRITE_DATA: assert property (($fell(EXTERNAL_DATA_STROBE_N) && !READ_WRITE) |-> DATA_OE) // R3
    else $error("Write data missing while strobe low.");
  AST_EIGHTH_FOLLOW: assert property ((!EIGHTH_BANK_SELECT_FIRST_N || !EIGHTH_BANK_SELECT_SECOND_N)
      |-> !EXTERNAL_DATA_STROBE_N) // R4
    else $error("Eighth select active without strobe.");
  AST_HALF_FOLLOW: assert property ((!HALF_BANK_SELECT_FIRST_N || !HALF_BANK_SELECT_SECOND_N ||
      !HALF_BANK_SELECT_THIRD_N) |-> !EXTERNAL_DATA_STROBE_N) // R5
    else $error("Half select active without strobe.");
  AST_PARK: assert property ((BANK_PARK_HIGH[4] && $stable(BANK_PARK_HIGH)) |=>
      EIGHTH_BANK_SELECT_FIRST_N) // R6
    else $error("Parked bank select was driven low.");
  AST_PF_RANGE: assert property (!PERIPHERAL_FRAME_SELECT_N |->
      in_frame({ADDRESS_HIGH_BYTE_PORT, ADDRESS_LOW_BYTE_PORT})) // R7
    else $error("Peripheral select outside its frames.");
  AST_EIGHTH_DECODE: assert property (!EIGHTH_BANK_SELECT_SECOND_N |->
      (ADDRESS_HIGH_BYTE_PORT[7:5] == EIGHTH_SECOND_BLK)) // R8
    else $error("Eighth select does not match address.");
  AST_RW_WRITE: assert property (DATA_OE |-> !READ_WRITE) // R9
    else $error("Direction high while write data driven.");
  AST_OCF_END: assert property ($rose(REQ_ACK) |=> OPCODE_FETCH_INDICATOR_N) // R10
    else $error("Fetch indicator not released after access.");
  AST_ADDR_HOLD: assert property (!EXTERNAL_DATA_STROBE_N |->
      $stable({ADDRESS_HIGH_BYTE_PORT, ADDRESS_LOW_BYTE_PORT})) // R11
    else $error("Address changed during strobe.");
  AST_SEL_IDLE: assert property (EXTERNAL_DATA_STROBE_N |-> (PERIPHERAL_FRAME_SELECT_N &&
      HALF_BANK_SELECT_THIRD_N && EIGHTH_BANK_SELECT_FIRST_N)) // R12
    else $error("Select active with strobe high.");

  COV_EXT_READ: cover property ($rose(REQ_ACK) && READ_WRITE && !acc_write && acc_ext);
  COV_EXT_WRITE: cover property (DATA_OE && !EXTERNAL_DATA_STROBE_N);
  COV_PF_ACCESS: cover property (!PERIPHERAL_FRAME_SELECT_N);
  COV_FETCH: cover property (!OPCODE_FETCH_INDICATOR_N && !EXTERNAL_DATA_STROBE_N);
endmodule
`default_nettype wire

//--- design/ebcs_pkg.sv
// Constants and types shared by the expansion bus chip-select logic.
// What this block does
// R1: Strobe low during external access, else high.
// R2: Read data taken at strobe rising edge.
// R3: Write data driven from strobe falling edge.
// R4: Two eighth-range selects mirror strobe timing.
// R5: Three half-range selects mirror strobe timing.
// R6: Parked-high select pin disables its bank.
// R7: Peripheral select only for 10C0h to 10FFh.
// R8: Selects decoded from top address bits.
// R9: Direction high for reads, low for writes.
// R10: Fetch indicator low during opcode first-byte read.
// R11: Address out on low and high byte ports.
// R12: All selects active low, idle high.
`default_nettype none
package ebcs_pkg;
  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [15:0] PF_FRAME_LO = 16'h10C0;
  localparam logic [15:0] PF_FRAME_HI = 16'h10FF;
  localparam logic [15:0] EXT_BASE = 16'h2000;
  localparam logic [2:0] EIGHTH_FIRST_BLK = 3'h1;
  localparam logic [2:0] EIGHTH_SECOND_BLK = 3'h7;
  localparam logic [1:0] HALF_FIRST_BLK = 2'h1;
  localparam logic [1:0] HALF_SECOND_BLK = 2'h2;
  localparam logic [1:0] HALF_THIRD_BLK = 2'h3;
  // ****************************************************************
  // Timing and reset values
  // ****************************************************************
  localparam int STROBE_CYCLES_DEF = 3;
  localparam int SYNC_STAGES = 2;
  localparam logic [4:0] SEL_IDLE = 5'h1F;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD} ebcs_state_t;
endpackage
`default_nettype wire

//--- design/ebcs_sync.sv
// Two-stage synchroniser for the external data bus input.
`default_nettype none
module ebcs_sync
  import ebcs_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second, so metastability cannot spread.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1 <= '0;
      dout <= '0;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule
`default_nettype wire

//--- design/ebcs_unused_placeholder_never.sv
// Intentionally empty of logic; holds no module.
`default_nettype none
`default_nettype wire

//--- sim/ebcs_mem_model.sv
// Behavioural external memory on the expansion bus.
`default_nettype none
module ebcs_mem_model
(
  // Clock
  input wire logic clk,
  // Bus pins
  input wire logic strobe_n,
  input wire logic read_write,
  input wire logic [7:0] addr_lo,
  input wire logic [7:0] wdata,
  input wire logic wdata_oe,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  // A released bus shows the inverse of the last byte, so stale data never passes.
  assign rdata = (!strobe_n && read_write) ? mem[addr_lo] : ~last;
  always @(posedge clk)
  begin
    if (!strobe_n && read_write)
    begin
      last <= mem[addr_lo];
    end
    if (!strobe_n && !read_write && wdata_oe)
    begin
      mem[addr_lo] <= wdata;
    end
  end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the expansion bus chip-select block.
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
  $display("Error %s exp %h got %h", nm, ex, got); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ebcs_pkg::*;
  logic CLK_SYS = 0, RST = 1, REQ_VALID = 0, REQ_WRITE = 0, REQ_FETCH = 0;
  logic [15:0] REQ_ADDR = 16'h0000;
  logic [7:0] REQ_WDATA = 8'h00;
  logic [4:0] BANK_PARK_HIGH = 5'h00;
  logic REQ_READY, REQ_ACK, READ_WRITE, OCF_N, STR_N, PF_N, DATA_OE;
  logic [7:0] RD_DATA, A_LO, A_HI, DATA_IN, DATA_OUT;
  wire [4:0] sel_n;
  logic [4:0] sel_lo;
  logic str_lo, pf_lo, rw_lo, ocf_lo, oe_seen, bad_timing;
  int error_cnt = 0, checked = 0;
  ebcs_top ebcs_top_inst (.CLK_SYS(CLK_SYS), .RST(RST), .REQ_VALID(REQ_VALID),
    .REQ_ADDR(REQ_ADDR), .REQ_WRITE(REQ_WRITE), .REQ_FETCH(REQ_FETCH),
    .REQ_WDATA(REQ_WDATA), .BANK_PARK_HIGH(BANK_PARK_HIGH), .REQ_READY(REQ_READY),
    .REQ_ACK(REQ_ACK), .RD_DATA(RD_DATA), .ADDRESS_LOW_BYTE_PORT(A_LO),
    .ADDRESS_HIGH_BYTE_PORT(A_HI), .READ_WRITE(READ_WRITE),
    .OPCODE_FETCH_INDICATOR_N(OCF_N), .EXTERNAL_DATA_STROBE_N(STR_N),
    .EIGHTH_BANK_SELECT_FIRST_N(sel_n[4]), .EIGHTH_BANK_SELECT_SECOND_N(sel_n[3]),
    .HALF_BANK_SELECT_FIRST_N(sel_n[2]), .HALF_BANK_SELECT_SECOND_N(sel_n[1]),
    .HALF_BANK_SELECT_THIRD_N(sel_n[0]), .PERIPHERAL_FRAME_SELECT_N(PF_N),
    .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE));
  ebcs_mem_model ebcs_mem_model_inst (.clk(CLK_SYS), .strobe_n(STR_N),
    .read_write(READ_WRITE), .addr_lo(A_LO), .wdata(DATA_OUT), .wdata_oe(DATA_OE),
    .rdata(DATA_IN));
  initial
  begin
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  // Pin activity is folded per access, so a short glitch is still seen.
  always @(negedge CLK_SYS)
  begin
    sel_lo |= ~sel_n;
    str_lo |= ~STR_N;
    pf_lo |= ~PF_N;
    rw_lo |= ~READ_WRITE;
    ocf_lo |= ~OCF_N;
    oe_seen |= DATA_OE;
    bad_timing |= ((sel_n != 5'h1F) || !PF_N) && STR_N;
  end
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic acc(input logic [15:0] a, input logic w, input logic f,
                     input logic [7:0] d);
    int n;
    @(negedge CLK_SYS);
    for (n = 0; n < 20 && REQ_READY !== 1'b1; n++) @(negedge CLK_SYS);
    {sel_lo, str_lo, pf_lo, rw_lo, ocf_lo, oe_seen, bad_timing} = 11'h000;
    REQ_VALID = 1;
    REQ_ADDR = a;
    REQ_WRITE = w;
    REQ_FETCH = f;
    REQ_WDATA = d;
    @(negedge CLK_SYS);
    REQ_VALID = 0;
    for (n = 0; n < 20 && REQ_ACK !== 1'b1; n++) @(negedge CLK_SYS);
    `CHK("ack", 1'b1, REQ_ACK)
    @(negedge CLK_SYS);
    `CHK("address", a, {A_HI, A_LO})
    `CHK("idle pins", 7'h7F, {STR_N, sel_n, PF_N})
    `CHK("select timing", 1'b0, bad_timing)
  endtask
  task automatic t_banks();
    logic [15:0] adr [8] = '{16'h2000, 16'h3FFF, 16'hE000, 16'h4000, 16'h7FFF,
                             16'h8000, 16'hC000, 16'hDFFF};
    logic [4:0] exp [8] = '{5'h10, 5'h10, 5'h08, 5'h04, 5'h04, 5'h02, 5'h01, 5'h01};
    for (int i = 0; i < 8; i++)
    begin
      acc(adr[i], 1'b1, 1'b0, 8'h00);
      `CHK("bank select", exp[i], sel_lo)
      `CHK("strobe", 1'b1, str_lo)
      BANK_PARK_HIGH = exp[i];
      acc(adr[i], 1'b1, 1'b0, 8'h00);
      `CHK("parked select", 5'h00, sel_lo)
      BANK_PARK_HIGH = 5'h00;
    end
    $display("Test banks done");
  endtask
  task automatic t_frames();
    logic [15:0] adr [5] = '{16'h10C0, 16'h10FF, 16'h10BF, 16'h1100, 16'h0FFF};
    logic exp [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 5; i++)
    begin
      acc(adr[i], 1'b1, 1'b0, 8'h00);
      `CHK("frame select", exp[i], pf_lo)
      `CHK("frame strobe", exp[i], str_lo)
      `CHK("frame banks", 5'h00, sel_lo)
    end
    $display("Test frames done");
  endtask
  task automatic t_data();
    acc(16'h2011, 1'b1, 1'b0, 8'h3C);
    acc(16'hE012, 1'b1, 1'b0, 8'hA5);
    `CHK("write dir", 1'b1, rw_lo)
    `CHK("write drive", 1'b1, oe_seen)
    acc(16'h4012, 1'b0, 1'b1, 8'h00);
    `CHK("fetch flag", 1'b1, ocf_lo)
    `CHK("read dir", 1'b0, rw_lo)
    `CHK("read data", 8'hA5, RD_DATA)
    acc(16'h0011, 1'b0, 1'b0, 8'h00);
    `CHK("plain read flag", 1'b0, ocf_lo)
    `CHK("internal read dir", 1'b0, rw_lo)
    `CHK("internal strobe", 1'b0, str_lo)
    acc(16'h0011, 1'b1, 1'b1, 8'h00);
    `CHK("write fetch flag", 1'b0, ocf_lo)
    `CHK("internal write dir", 1'b1, rw_lo)
    `CHK("internal write strobe", 1'b0, str_lo)
    `CHK("internal write drive", 1'b0, oe_seen)
    acc(16'h3011, 1'b0, 1'b0, 8'h00);
    `CHK("read data 2", 8'h3C, RD_DATA)
    $display("Test data done");
  endtask
  initial
  begin
    repeat (20) @(negedge CLK_SYS);
    RST = 0;
    t_banks();
    t_frames();
    t_data();
    tally_and_finish();
  end
  initial
  begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
